// file: design/memory_map_vector_decoder.sv
// Address classifier for the internal memory map with vector redirect.
//
// How it works
// RULE1: 128 KB ROM, rest of 1 MB prohibited.
// RULE2: 256 KB ROM, rest of 1 MB prohibited.
// RULE3: 384 KB ROM, rest of 1 MB prohibited.
// RULE4: 512 KB ROM, rest of 1 MB prohibited.
// RULE5: Granted request redirects fetch to handler.
// RULE6: Reset, NMI, watchdog NMI fixed vectors.
// RULE7: Trap groups share vectors; illegal opcode vector.
// RULE8: Maskable vectors spaced sixteen bytes apart.
// RULE9: Two-wire vectors only when controller present.
// RULE10: 28 KB RAM area below peripheral area.
// RULE11: 8 KB RAM usable, lower part prohibited.
// RULE12: Upper eight address bits are ignored.
// RULE13: One-cycle pulse on prohibited access.
`timescale 1ns/1ps
`default_nettype none
module memory_map_vector_decoder
  import memmap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cpu_addr_valid,
  input wire logic [31:0] cpu_addr,
  input wire logic [1:0] rom_size_sel,
  input wire logic two_wire_present,
  input wire logic irq_grant,
  input wire logic [3:0] grant_class,
  input wire logic [4:0] grant_index,
  output logic rom_hit,
  output logic ram_hit,
  output logic io_hit,
  output logic ext_hit,
  output logic access_prohibited,
  output logic fetch_redirect,
  output logic [31:0] fetch_target,
  output logic grant_refused
);

  typedef struct packed {
    logic rom_hit;
    logic ram_hit;
    logic io_hit;
    logic ext_hit;
    logic prohibited;
    logic redirect;
    logic [31:0] target;
    logic refused;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [23:0] phys;
  logic in_rom_region;
  logic rom_usable;
  logic in_ram_area;
  logic ram_usable;
  logic in_io_area;
  logic [31:0] table_addr;
  logic table_ok;

  vector_table u_vector_table (
    .src_class(grant_class),
    .src_index(grant_index),
    .two_wire_present(two_wire_present),
    .vec_addr(table_addr),
    .vec_ok(table_ok)
  );

  // RULE12: drop upper bits
  assign phys = cpu_addr[23:0];

  // RULE1: ROM size limit
  // RULE2: ROM size limit
  // RULE3: ROM size limit
  // RULE4: ROM size limit
  assign in_rom_region = (phys <= ROM_REGION_LAST);
  assign rom_usable = in_rom_region && (phys < rom_limit(rom_size_sel));

  // RULE10: RAM area bounds
  assign in_ram_area = (phys >= RAM_AREA_FIRST) && (phys <= RAM_AREA_LAST);
  // RULE11: 8 KB usable part
  assign ram_usable = (phys >= RAM_8K_FIRST) && (phys <= RAM_AREA_LAST);
  assign in_io_area = (phys >= IO_AREA_FIRST);

  always_comb begin
    state_next = '0;
    state_next.target = state_reg.target;
    if (cpu_addr_valid) begin
      state_next.rom_hit = rom_usable;
      state_next.ram_hit = ram_usable;
      state_next.io_hit = in_io_area;
      state_next.ext_hit = !in_rom_region && !in_ram_area && !in_io_area;
      // RULE13: flag prohibited holes
      state_next.prohibited = (in_rom_region && !rom_usable) ||
                              (in_ram_area && !ram_usable);
    end
    // RULE5: redirect on grant
    if (irq_grant) begin
      if (table_ok) begin
        state_next.redirect = 1'b1;
        state_next.target = table_addr;
      end else begin
        state_next.refused = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rom_hit = state_reg.rom_hit;
  assign ram_hit = state_reg.ram_hit;
  assign io_hit = state_reg.io_hit;
  assign ext_hit = state_reg.ext_hit;
  assign access_prohibited = state_reg.prohibited;
  assign fetch_redirect = state_reg.redirect;
  assign fetch_target = state_reg.target;
  assign grant_refused = state_reg.refused;

  // The outputs lag the address by one cycle; the bus logic that uses
  // them must hold or pipeline the access to match.

  property p_rom_map(logic [1:0] sel, logic [23:0] lim);
    @(posedge clk) disable iff (!rst_b)
      (cpu_addr_valid && rom_size_sel == sel && cpu_addr[23:0] < lim)
      |=> (rom_hit && !access_prohibited && !ext_hit);
  endproperty

  property p_rom_hole(logic [1:0] sel, logic [23:0] lim);
    @(posedge clk) disable iff (!rst_b)
      (cpu_addr_valid && rom_size_sel == sel && cpu_addr[23:0] >= lim &&
       cpu_addr[23:0] <= ROM_REGION_LAST)
      |=> (access_prohibited && !rom_hit);
  endproperty

  a_rom_small_map: assert property ( // RULE1
      p_rom_map(ROM_SEL_128K, ROM_LIMIT_128K))
    else $error("128 KB ROM address not mapped to ROM");
  a_rom_small_hole: assert property ( // RULE1
      p_rom_hole(ROM_SEL_128K, ROM_LIMIT_128K))
    else $error("128 KB ROM hole not prohibited");
  a_rom_256_map: assert property ( // RULE2
      p_rom_map(ROM_SEL_256K, ROM_LIMIT_256K))
    else $error("256 KB ROM address not mapped to ROM");
  a_rom_256_hole: assert property ( // RULE2
      p_rom_hole(ROM_SEL_256K, ROM_LIMIT_256K))
    else $error("256 KB ROM hole not prohibited");
  a_rom_384_map: assert property ( // RULE3
      p_rom_map(ROM_SEL_384K, ROM_LIMIT_384K))
    else $error("384 KB ROM address not mapped to ROM");
  a_rom_384_hole: assert property ( // RULE3
      p_rom_hole(ROM_SEL_384K, ROM_LIMIT_384K))
    else $error("384 KB ROM hole not prohibited");
  a_rom_512_map: assert property ( // RULE4
      p_rom_map(ROM_SEL_512K, ROM_LIMIT_512K))
    else $error("512 KB ROM address not mapped to ROM");
  a_rom_512_hole: assert property ( // RULE4
      p_rom_hole(ROM_SEL_512K, ROM_LIMIT_512K))
    else $error("512 KB ROM hole not prohibited");

  sequence s_good_grant;
    irq_grant && table_ok;
  endsequence

  sequence s_redirect_pulse;
    fetch_redirect && !grant_refused && (fetch_target == $past(table_addr));
  endsequence

  // Two accesses in a row to one 24-bit location, decode size unchanged.
  sequence s_same_location_pair;
    cpu_addr_valid ##1 cpu_addr_valid && $stable(cpu_addr[23:0]) &&
    $stable(rom_size_sel);
  endsequence

  // RULE5: redirect to handler
  a_redirect_target: assert property ( // RULE5
    @(posedge clk) disable iff (!rst_b)
    s_good_grant |=> s_redirect_pulse)
    else $error("granted request did not redirect to handler");
  a_redirect_cause: assert property ( // RULE5
    @(posedge clk) disable iff (!rst_b)
    fetch_redirect |-> $past(irq_grant) && !grant_refused)
    else $error("redirect without a grant");

  a_fixed_vectors: assert property ( // RULE6
    @(posedge clk) disable iff (!rst_b)
    irq_grant && (grant_class == SRC_RESET || grant_class == SRC_NMI ||
                  grant_class == SRC_WDT_NMI)
    |=> fetch_target == (($past(grant_class) == SRC_RESET) ? VEC_RESET :
                         ($past(grant_class) == SRC_NMI) ? VEC_NMI :
                         VEC_WDT_NMI))
    else $error("fixed exception vector wrong");

  a_trap_vectors: assert property ( // RULE7
    @(posedge clk) disable iff (!rst_b)
    irq_grant && (grant_class == SRC_TRAP_A || grant_class == SRC_TRAP_B ||
                  grant_class == SRC_ILLEGAL_OP)
    |=> fetch_redirect && fetch_target ==
        (($past(grant_class) == SRC_TRAP_A) ? VEC_TRAP_A :
         ($past(grant_class) == SRC_TRAP_B) ? VEC_TRAP_B :
         VEC_ILLEGAL_OP))
    else $error("trap or illegal opcode vector wrong");

  a_pin_spacing: assert property ( // RULE8
    @(posedge clk) disable iff (!rst_b)
    irq_grant && grant_class == SRC_EXT_PIN && grant_index < PIN_COUNT
    |=> fetch_target == VEC_PIN_BASE + 32'({$past(grant_index), 4'h0}))
    else $error("external pin vector spacing wrong");
  a_onchip_spacing: assert property ( // RULE8
    @(posedge clk) disable iff (!rst_b)
    irq_grant && grant_class == SRC_ONCHIP
    |=> fetch_target == VEC_ONCHIP_BASE + 32'({$past(grant_index), 4'h0}))
    else $error("on-chip vector spacing wrong");

  a_two_wire_gate: assert property ( // RULE9
    @(posedge clk) disable iff (!rst_b)
    irq_grant && !two_wire_present &&
    (grant_class == SRC_TWO_WIRE_A || grant_class == SRC_TWO_WIRE_B)
    |=> grant_refused && !fetch_redirect)
    else $error("two-wire vector delivered without the controller");

  a_ram_area: assert property ( // RULE10
    @(posedge clk) disable iff (!rst_b)
    ram_hit || (access_prohibited &&
                !$past(cpu_addr[23:0] <= ROM_REGION_LAST))
    |-> $past(cpu_addr[23:0]) >= RAM_AREA_FIRST &&
        $past(cpu_addr[23:0]) < IO_AREA_FIRST)
    else $error("RAM area decode outside its 28 KB window");

  a_ram_8k_split: assert property ( // RULE11
    @(posedge clk) disable iff (!rst_b)
    cpu_addr_valid && cpu_addr[23:0] >= RAM_AREA_FIRST &&
    cpu_addr[23:0] <= RAM_AREA_LAST
    |=> (ram_hit != access_prohibited) &&
        (ram_hit == ($past(cpu_addr[23:0]) >= RAM_8K_FIRST)))
    else $error("8 KB RAM window or its hole decoded wrongly");

  a_alias_ignore: assert property ( // RULE12
    @(posedge clk) disable iff (!rst_b)
    s_same_location_pair
    |=> $stable({rom_hit, ram_hit, io_hit, ext_hit, access_prohibited}))
    else $error("upper address bits changed the decode");

  a_prohibit_pulse: assert property ( // RULE13
    @(posedge clk) disable iff (!rst_b)
    !cpu_addr_valid |=> !access_prohibited && !rom_hit && !ram_hit &&
                        !io_hit && !ext_hit)
    else $error("decode flag without an access");

endmodule // memory_map_vector_decoder
`default_nettype wire

// file: common/memmap_pkg.sv
// Address map, vector table constants and source encodings for the decoder.
package memmap_pkg;

  // Internal ROM or flash region, the lowest 1 MB of every 16 MB block.
  localparam logic [23:0] ROM_REGION_LAST = 24'h0F_FFFF;
  localparam logic [23:0] ROM_LIMIT_128K = 24'h02_0000;
  localparam logic [23:0] ROM_LIMIT_256K = 24'h04_0000;
  localparam logic [23:0] ROM_LIMIT_384K = 24'h06_0000;
  localparam logic [23:0] ROM_LIMIT_512K = 24'h08_0000;

  // ROM size select codes.
  localparam logic [1:0] ROM_SEL_128K = 2'h0;
  localparam logic [1:0] ROM_SEL_256K = 2'h1;
  localparam logic [1:0] ROM_SEL_384K = 2'h2;
  localparam logic [1:0] ROM_SEL_512K = 2'h3;

  // Internal RAM area of 28 KB, of which the 8 KB variant uses the top part.
  localparam logic [23:0] RAM_AREA_FIRST = 24'hFF_8000;
  localparam logic [23:0] RAM_8K_FIRST = 24'hFF_D000;
  localparam logic [23:0] RAM_AREA_LAST = 24'hFF_EFFF;
  localparam logic [23:0] IO_AREA_FIRST = 24'hFF_F000;

  // Handler start addresses.
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_NMI = 32'h0000_0010;
  localparam logic [31:0] VEC_WDT_NMI = 32'h0000_0020;
  localparam logic [31:0] VEC_TRAP_A = 32'h0000_0040;
  localparam logic [31:0] VEC_TRAP_B = 32'h0000_0050;
  localparam logic [31:0] VEC_ILLEGAL_OP = 32'h0000_0060;
  localparam logic [31:0] VEC_WDT_MASK = 32'h0000_0080;
  localparam logic [31:0] VEC_PIN_BASE = 32'h0000_0090;
  localparam logic [31:0] VEC_ONCHIP_BASE = 32'h0000_0140;
  localparam logic [31:0] VEC_TWO_WIRE_A = 32'h0000_01F0;
  localparam logic [31:0] VEC_TWO_WIRE_B = 32'h0000_0240;
  localparam logic [4:0] PIN_COUNT = 5'h07;
  localparam int unsigned VEC_SHIFT = 4;

  typedef enum logic [3:0] {
    SRC_RESET = 4'h0,
    SRC_NMI = 4'h1,
    SRC_WDT_NMI = 4'h2,
    SRC_TRAP_A = 4'h3,
    SRC_TRAP_B = 4'h4,
    SRC_ILLEGAL_OP = 4'h5,
    SRC_WDT_MASK = 4'h6,
    SRC_EXT_PIN = 4'h7,
    SRC_ONCHIP = 4'h8,
    SRC_TWO_WIRE_A = 4'h9,
    SRC_TWO_WIRE_B = 4'hA
  } src_class_t;

  // First address past usable ROM for the selected size.
  function automatic logic [23:0] rom_limit(input logic [1:0] sel);
    logic [23:0] lim;
    lim = ROM_LIMIT_128K;
    unique case (sel)
      ROM_SEL_128K: lim = ROM_LIMIT_128K;
      ROM_SEL_256K: lim = ROM_LIMIT_256K;
      ROM_SEL_384K: lim = ROM_LIMIT_384K;
      ROM_SEL_512K: lim = ROM_LIMIT_512K;
    endcase
    return lim;
  endfunction

  // Vectors of one group are spaced 16 bytes apart from the group base.
  function automatic logic [31:0] vec_at(input logic [31:0] base,
                                         input logic [4:0] idx);
    return base + (32'(idx) << VEC_SHIFT);
  endfunction

endpackage

// file: design/vector_table.sv
// Fixed lookup from interrupt or exception source to handler address.
`timescale 1ns/1ps
`default_nettype none
module vector_table
  import memmap_pkg::*;
(
  input wire logic [3:0] src_class,
  input wire logic [4:0] src_index,
  input wire logic two_wire_present,
  output logic [31:0] vec_addr,
  output logic vec_ok
);

  always_comb begin
    vec_addr = VEC_RESET;
    vec_ok = 1'b1;
    unique case (src_class)
      // RULE6: fixed exception vectors
      SRC_RESET: vec_addr = VEC_RESET;
      SRC_NMI: vec_addr = VEC_NMI;
      SRC_WDT_NMI: vec_addr = VEC_WDT_NMI;
      // RULE7: trap and illegal opcode
      // Every trap of a group shares one entry; the index is ignored.
      SRC_TRAP_A: vec_addr = VEC_TRAP_A;
      SRC_TRAP_B: vec_addr = VEC_TRAP_B;
      SRC_ILLEGAL_OP: vec_addr = VEC_ILLEGAL_OP;
      SRC_WDT_MASK: vec_addr = VEC_WDT_MASK;
      // RULE8: sixteen byte spacing
      SRC_EXT_PIN: begin
        vec_addr = vec_at(VEC_PIN_BASE, src_index);
        vec_ok = (src_index < PIN_COUNT);
      end
      SRC_ONCHIP: vec_addr = vec_at(VEC_ONCHIP_BASE, src_index);
      // RULE9: two-wire vector gating
      // Without the two-wire controller these entries belong to other
      // on-chip sources, so a two-wire request there is not honoured.
      SRC_TWO_WIRE_A: begin
        vec_addr = VEC_TWO_WIRE_A;
        vec_ok = two_wire_present;
      end
      SRC_TWO_WIRE_B: begin
        vec_addr = VEC_TWO_WIRE_B;
        vec_ok = two_wire_present;
      end
      default: vec_ok = 1'b0;
    endcase
  end

endmodule // vector_table
`default_nettype wire

// file: testbench/cpu_core_model.sv
// CPU core model that issues addresses and interrupt grants.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic clk,
  output logic cpu_addr_valid,
  output logic [31:0] cpu_addr,
  output logic irq_grant,
  output logic [3:0] grant_class,
  output logic [4:0] grant_index
);
  initial begin
    cpu_addr_valid = 1'b0;
    cpu_addr = 32'h0000_0000;
    irq_grant = 1'b0;
    grant_class = 4'h0;
    grant_index = 5'h00;
  end
  // A second call at the next edge runs back to back with the first.
  task automatic access(input logic [31:0] a);
    @(negedge clk);
    cpu_addr_valid <= 1'b1;
    cpu_addr <= a;
  endtask
  task automatic grant(input logic [3:0] c, input logic [4:0] i);
    @(negedge clk);
    irq_grant <= 1'b1;
    grant_class <= c;
    grant_index <= i;
  endtask
  // Idle lines carry the inverse of the last value, so a decoder that
  // samples them outside a request sees noise rather than a stale match.
  task automatic idle();
    @(negedge clk);
    cpu_addr_valid <= 1'b0;
    cpu_addr <= ~cpu_addr;
    irq_grant <= 1'b0;
    grant_class <= ~grant_class;
    grant_index <= ~grant_index;
  endtask
endmodule // cpu_core_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the memory map and vector decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import memmap_pkg::*;
  typedef struct packed {logic [31:0] a; logic [1:0] s;
    logic [4:0] f;} arow_t;
  typedef struct packed {logic [3:0] c; logic [4:0] i; logic p; logic r;
    logic [31:0] t;} vrow_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] rom_size_sel = 2'h0;
  logic two_wire_present = 1'b0;
  logic cpu_addr_valid, irq_grant;
  logic [31:0] cpu_addr, fetch_target;
  logic [3:0] grant_class;
  logic [4:0] grant_index;
  logic rom_hit, ram_hit, io_hit, ext_hit, access_prohibited;
  logic fetch_redirect, grant_refused;
  wire logic [4:0] flags;
  int num_errors = 0;
  int check_count = 0;
  // Flag order: rom, ram, io, ext, prohibited.
  arow_t ar [16] = '{
    '{32'hAB01_FFFF, 2'h0, 5'h10}, '{32'h0002_0000, 2'h0, 5'h01},
    '{32'h0103_FFFF, 2'h1, 5'h10}, '{32'hFF04_0000, 2'h1, 5'h01},
    '{32'h0005_FFFF, 2'h2, 5'h10}, '{32'h7706_0000, 2'h2, 5'h01},
    '{32'h0007_FFFF, 2'h3, 5'h10}, '{32'h0008_0000, 2'h3, 5'h01},
    '{32'h000F_FFFF, 2'h3, 5'h01}, '{32'h0010_0000, 2'h3, 5'h02},
    '{32'h00FF_7FFF, 2'h0, 5'h02}, '{32'h12FF_8000, 2'h0, 5'h01},
    '{32'h00FF_CFFF, 2'h1, 5'h01}, '{32'h00FF_D000, 2'h2, 5'h08},
    '{32'h55FF_EFFF, 2'h3, 5'h08}, '{32'h00FF_F000, 2'h0, 5'h04}};
  // A refused grant leaves the target of the row before it.
  vrow_t vr [17] = '{
    '{4'h0, 5'h00, 1'b0, 1'b0, 32'h0000_0000},
    '{4'h1, 5'h00, 1'b0, 1'b0, 32'h0000_0010},
    '{4'h2, 5'h00, 1'b0, 1'b0, 32'h0000_0020},
    '{4'h3, 5'h05, 1'b0, 1'b0, 32'h0000_0040},
    '{4'h4, 5'h1F, 1'b0, 1'b0, 32'h0000_0050},
    '{4'h5, 5'h00, 1'b0, 1'b0, 32'h0000_0060},
    '{4'h6, 5'h00, 1'b0, 1'b0, 32'h0000_0080},
    '{4'h7, 5'h00, 1'b0, 1'b0, 32'h0000_0090},
    '{4'h7, 5'h06, 1'b0, 1'b0, 32'h0000_00F0},
    '{4'h7, 5'h07, 1'b0, 1'b1, 32'h0000_00F0},
    '{4'h8, 5'h00, 1'b0, 1'b0, 32'h0000_0140},
    '{4'h8, 5'h1F, 1'b0, 1'b0, 32'h0000_0330},
    '{4'h8, 5'h0B, 1'b0, 1'b0, 32'h0000_01F0},
    '{4'h9, 5'h00, 1'b1, 1'b0, 32'h0000_01F0},
    '{4'hA, 5'h00, 1'b0, 1'b1, 32'h0000_01F0},
    '{4'hA, 5'h00, 1'b1, 1'b0, 32'h0000_0240},
    '{4'hF, 5'h00, 1'b1, 1'b1, 32'h0000_0240}};

  assign flags = {rom_hit, ram_hit, io_hit, ext_hit, access_prohibited};
  always #5 clk = ~clk;

  cpu_core_model i_cpu_core_model (.clk(clk),
    .cpu_addr_valid(cpu_addr_valid), .cpu_addr(cpu_addr),
    .irq_grant(irq_grant), .grant_class(grant_class),
    .grant_index(grant_index));
  memory_map_vector_decoder i_memory_map_vector_decoder (.clk(clk),
    .rst_b(rst_b), .cpu_addr_valid(cpu_addr_valid), .cpu_addr(cpu_addr),
    .rom_size_sel(rom_size_sel), .two_wire_present(two_wire_present),
    .irq_grant(irq_grant), .grant_class(grant_class),
    .grant_index(grant_index), .rom_hit(rom_hit), .ram_hit(ram_hit),
    .io_hit(io_hit), .ext_hit(ext_hit),
    .access_prohibited(access_prohibited),
    .fetch_redirect(fetch_redirect), .fetch_target(fetch_target),
    .grant_refused(grant_refused));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_vec(input logic r, input logic [31:0] t);
    check({31'h0, fetch_redirect}, {31'h0, ~r});
    check({31'h0, grant_refused}, {31'h0, r});
    check(fetch_target, t);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge clk);
    check({27'h0, flags}, 32'h0000_0000);
    check(fetch_target, 32'h0000_0000);
    rst_b <= 1'b1;
    foreach (ar[k]) begin
      rom_size_sel <= ar[k].s;
      i_cpu_core_model.access(ar[k].a);
      i_cpu_core_model.idle();
      check({27'h0, flags}, {27'h0, ar[k].f});
    end
    $display("address table done");
    foreach (vr[k]) begin
      two_wire_present <= vr[k].p;
      i_cpu_core_model.grant(vr[k].c, vr[k].i);
      i_cpu_core_model.idle();
      check_vec(vr[k].r, vr[k].t);
    end
    $display("vector table done");
    rom_size_sel <= ROM_SEL_128K;
    i_cpu_core_model.access(32'h0001_0000);
    i_cpu_core_model.access(32'h0003_0000);
    check({27'h0, flags}, 32'h0000_0010);
    // Same 24-bit location again through another alias.
    i_cpu_core_model.access(32'hAB03_0000);
    check({27'h0, flags}, 32'h0000_0001);
    i_cpu_core_model.idle();
    check({27'h0, flags}, 32'h0000_0001);
    i_cpu_core_model.idle();
    check({27'h0, flags}, 32'h0000_0000);
    i_cpu_core_model.grant(4'h7, 5'h02);
    i_cpu_core_model.grant(4'h3, 5'h00);
    check_vec(1'b0, 32'h0000_00B0);
    i_cpu_core_model.idle();
    check_vec(1'b0, 32'h0000_0040);
    i_cpu_core_model.idle();
    check({31'h0, fetch_redirect}, 32'h0000_0000);
    $display("back to back done");
    // A reset in mid-run must clear the target and drop every flag.
    i_cpu_core_model.access(32'h00FF_D000);
    rst_b <= 1'b0;
    i_cpu_core_model.idle();
    check({27'h0, flags}, 32'h0000_0000);
    check(fetch_target, 32'h0000_0000);
    rst_b <= 1'b1;
    i_cpu_core_model.access(32'hC3FF_D000);
    check({27'h0, flags}, 32'h0000_0000);
    i_cpu_core_model.idle();
    check({27'h0, flags}, 32'h0000_0008);
    check(fetch_target, 32'h0000_0000);
    $display("reset test done");
    final_report();
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule // tb
`default_nettype wire
